// ==== include/fnsi_pkg.sv ====
`default_nettype none
package fnsi_pkg;
  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS   = 100;      // mclk at 10 MHz
  localparam int TICK_NS         = 500_000;  // half-millisecond base
  localparam int TICK_CYC        =
    (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS    = 1_000_000 / TICK_NS;
  localparam int STEP_MS         = 250;      // lamp test step
  localparam int STEP_TICKS      = STEP_MS * TICKS_PER_MS;
  localparam int LAMP_STEPS      = 8;        // lit steps, then dark
  localparam int FAST_CYCLE_MS   = 125;      // fast flash period
  localparam int SLOW_CYCLE_MS   = 1000;     // slow flash period
  localparam int FAST_HALF_TICKS = FAST_CYCLE_MS * TICKS_PER_MS / 2;
  localparam int SLOW_HALF_TICKS = SLOW_CYCLE_MS * TICKS_PER_MS / 2;
  localparam int DUP_WAIT_MS     = 2000;     // lone-station hint
  localparam int DUP_WAIT_TICKS  = DUP_WAIT_MS * TICKS_PER_MS;

  // ============================================================
  // indicator vector layout
  localparam int LED_W    = 8;
  localparam int LED_MN_G = 0;  // module/network green
  localparam int LED_MN_R = 1;  // module/network red
  localparam int LED_PO_G = 2;  // polled connection green
  localparam int LED_PO_R = 3;  // polled connection red
  localparam int LED_BS_G = 4;  // bit-strobe green
  localparam int LED_BS_R = 5;  // bit-strobe red
  localparam int LED_BF_R = 6;  // bus fault red
  localparam int LED_SF_R = 7;  // system fault red
  localparam logic [LED_W-1:0] LED_DARK = 8'h00;
  localparam logic [LED_W-1:0] LED_ONE  = 8'h01;

  // ============================================================
  // node states, gray along lamp -> check -> run
  typedef enum logic [1:0] {
    FNSI_LAMP = 2'b00,
    FNSI_DUP  = 2'b01,
    FNSI_RUN  = 2'b11,
    FNSI_FAIL = 2'b10
  } fnsi_state_t;

  // lamp test pattern: one lamp per step, dark past the end
  function automatic logic [LED_W-1:0] fnsi_lamp_led(
    input logic [3:0] step
  );
    logic [LED_W-1:0] v;
    v = LED_DARK;
    if (step < 4'(LAMP_STEPS))
      v = LED_ONE << step[2:0];
    return v;
  endfunction
endpackage
`default_nettype wire

// ==== include/fnsi_time_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// shared timebase: tick enable and flash phases
interface fnsi_time_if;
  logic tick;       // one-cycle pulse every half millisecond
  logic fastPhase;  // high half of the fast flash cycle
  logic slowPhase;  // high half of the slow flash cycle
  modport src (output tick, output fastPhase, output slowPhase);
  modport snk (input tick, input fastPhase, input slowPhase);
endinterface
`default_nettype wire

// ==== hw/fnsi_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// divider and flash phase generator
module fnsi_timebase
  import fnsi_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic mclk,
  input  wire logic resetn,
  fnsi_time_if.src  tb
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST  = PW'(TICK_CYCLES - 1);
  localparam logic [6:0]    FAST_LAST = 7'(FAST_HALF_TICKS - 1);
  localparam logic [9:0]    SLOW_LAST = 10'(SLOW_HALF_TICKS - 1);

  logic [PW-1:0] preCnt_q;   // clock prescaler
  logic          tick_q;     // half-ms enable
  logic [6:0]    fastCnt_q;  // ticks into fast half period
  logic [9:0]    slowCnt_q;  // ticks into slow half period
  logic          fast_q;     // fast phase
  logic          slow_q;     // slow phase

  // ============================================================
  // prescaler: one enable, no derived clocks
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      preCnt_q <= '0;
      tick_q   <= 1'b0;
    end
    else
    begin
      tick_q <= (preCnt_q == PRE_LAST);
      if (preCnt_q == PRE_LAST)
        preCnt_q <= '0;
      else
        preCnt_q <= preCnt_q + 1'b1;
    end
  end

  // ============================================================
  // equal halves from one common tick
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      fastCnt_q <= '0;
      slowCnt_q <= '0;
      fast_q    <= 1'b1;
      slow_q    <= 1'b1;
    end
    else if (tick_q)
    begin
      // both halves last the same tick count
      if (fastCnt_q == FAST_LAST)
      begin
        fastCnt_q <= '0;
        fast_q    <= ~fast_q;
      end
      else
        fastCnt_q <= fastCnt_q + 1'b1;
      if (slowCnt_q == SLOW_LAST)
      begin
        slowCnt_q <= '0;
        slow_q    <= ~slow_q;
      end
      else
        slowCnt_q <= slowCnt_q + 1'b1;
    end
  end

  assign tb.tick      = tick_q;
  assign tb.fastPhase = fast_q;
  assign tb.slowPhase = slow_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // slow phase flips exactly when its half count runs out
  slow_half_a: assert property (
    (tick_q && slowCnt_q == SLOW_LAST) |=> (slow_q != $past(slow_q)))
    else $error("slow flash half period wrong");
endmodule
`default_nettype wire

// ==== hw/fnsi_indicators.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Behaviour
// - lamp test steps green/red through three indicators
// - then bus and system fault, dark at end
// - address check follows the finished lamp test
// - duplicate found: leave bus, three indicators red
// - module indicator dark offline or during check
// - online unconnected or misconfigured: slow green flash
// - active master connection: module indicator steady green
// - minor fault or timeout: slow red flash
// - critical fault, bus-off, failed check: steady red
// - polled indicator fast green flash during check
// - polled dark offline or connection not activated
// - polled configuring or bad configuration: slow green
// - polled connection established: steady green
// - polled minor fault or timeout: slow red
// - polled critical fault, bus-off, failed check: red
// - faulting timeout stays latched until unit reset
// - check waits for a peer; 2 s hint
module fnsi_indicators
  import fnsi_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC  // shorten for simulation
)(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic nodeOnline,       // node is on the bus
  input  wire logic masterConnected,  // master connection active
  input  wire logic configFault,      // configuration missing/wrong
  input  wire logic pollActivated,    // master enabled polled type
  input  wire logic pollEstablished,  // polled connection up
  input  wire logic pollTimeout,      // polled connection timed out
  input  wire logic strobeTimeout,    // bit-strobe timed out
  input  wire logic minorFault,       // correctable fault
  input  wire logic majorFault,       // non-correctable fault
  input  wire logic busOff,           // controller in bus-off
  input  wire logic dupCheckPass,     // check saw no twin address
  input  wire logic dupAddrFound,     // another station has our address
  input  wire logic timeoutRespFault, // timeout response raises fault
  input  wire logic unitReset,        // outside reset of the fault
  output var  logic dupCheckActive,   // check in progress
  output var  logic busDisable,       // node taken off the bus
  output var  logic noPeerSeen,       // check outlasted the wait
  output var  logic faultLatched,     // latched timeout fault
  output var  logic moduleNetGreen,
  output var  logic moduleNetRed,
  output var  logic pollGreen,
  output var  logic pollRed,
  output var  logic strobeGreen,
  output var  logic strobeRed,
  output var  logic busFaultRed,
  output var  logic systemFaultRed
);
  localparam logic [8:0]  STEP_LAST = 9'(STEP_TICKS - 1);
  localparam logic [3:0]  STEP_END  = 4'(LAMP_STEPS);
  localparam logic [11:0] DUP_LAST  = 12'(DUP_WAIT_TICKS - 1);

  fnsi_time_if tb ();  // timebase bundle

  fnsi_state_t      state_q;     // node indicator state
  fnsi_state_t      state_d;
  logic [8:0]       stepCnt_q;   // ticks into lamp step
  logic [3:0]       stepIdx_q;   // lamp test step number
  logic [11:0]      dupCnt_q;    // ticks spent checking
  logic             noPeer_q;    // wait exceeded
  logic             latch_q;     // latched timeout fault
  logic             dupAct_q;    // check output flop
  logic             busDis_q;    // off-bus output flop
  logic [LED_W-1:0] led_q;       // indicator flops
  logic [LED_W-1:0] led_d;
  logic             critical;    // steady red cause
  logic             minorAny;    // slow red cause, module level
  logic             latchSet;    // timeout with faulting response

  // ============================================================
  // timebase
  fnsi_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .mclk   (mclk),
    .resetn (resetn),
    .tb     (tb.src)
  );

  // ============================================================
  // lamp test sequencing
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stepCnt_q <= '0;
      stepIdx_q <= '0;
    end
    else if (state_q == FNSI_LAMP && tb.tick && stepIdx_q < STEP_END)
    begin
      // advance every step period from power-on
      if (stepCnt_q == STEP_LAST)
      begin
        stepCnt_q <= '0;
        stepIdx_q <= stepIdx_q + 1'b1;
      end
      else
        stepCnt_q <= stepCnt_q + 1'b1;
    end
  end

  // ============================================================
  // node state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FNSI_LAMP:
      begin
        // dark step reached: the test is over
        if (stepIdx_q == STEP_END)
          state_d = FNSI_DUP;
      end
      FNSI_DUP:
      begin
        // twin address wins over a simultaneous pass
        if (dupAddrFound)
          state_d = FNSI_FAIL;
        else if (dupCheckPass)
          state_d = FNSI_RUN;
      end
      FNSI_RUN:
        state_d = FNSI_RUN;
      FNSI_FAIL:
        state_d = FNSI_FAIL;   // only a power-on reset leaves
      default:
        state_d = FNSI_LAMP;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state_q <= FNSI_LAMP;
    else
      state_q <= state_d;
  end

  // ============================================================
  // check wait counter; no timeout, it only raises a hint
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dupCnt_q <= '0;
      noPeer_q <= 1'b0;
    end
    else if (state_q != FNSI_DUP)
      noPeer_q <= 1'b0;
    else if (tb.tick)
    begin
      // stays in the check; flags a lonely bus
      if (dupCnt_q == DUP_LAST)
        noPeer_q <= 1'b1;
      else
        dupCnt_q <= dupCnt_q + 1'b1;
    end
  end

  // ============================================================
  // latched timeout fault; the set wins over the clear
  assign latchSet = timeoutRespFault && (pollTimeout || strobeTimeout);

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      latch_q <= 1'b0;
    else if (latchSet)
      latch_q <= 1'b1;
    else if (unitReset)
      latch_q <= 1'b0;
  end

  // ============================================================
  // indicator decode
  assign critical = majorFault || busOff;
  assign minorAny = minorFault || pollTimeout || strobeTimeout || latch_q;

  always_comb
  begin
    led_d = LED_DARK;
    case (state_q)
      FNSI_LAMP:
        led_d = fnsi_lamp_led(stepIdx_q);
      FNSI_DUP:
      begin
        // module indicator stays dark here
        led_d[LED_PO_G] = tb.fastPhase;
      end
      FNSI_FAIL:
      begin
        led_d[LED_MN_R] = 1'b1;
        led_d[LED_PO_R] = 1'b1;
        led_d[LED_BS_R] = 1'b1;
      end
      FNSI_RUN:
      begin
        // module/network indicator, most severe first
        if (critical)
          led_d[LED_MN_R] = 1'b1;
        else if (minorAny)
          led_d[LED_MN_R] = tb.slowPhase;
        else if (!nodeOnline)
          led_d[LED_MN_G] = 1'b0;
        else if (masterConnected && !configFault)
          led_d[LED_MN_G] = 1'b1;
        else
          led_d[LED_MN_G] = tb.slowPhase;
        // polled connection indicator
        if (critical)
          led_d[LED_PO_R] = 1'b1;
        else if (minorFault || pollTimeout || latch_q)
          led_d[LED_PO_R] = tb.slowPhase;
        else if (!nodeOnline || !pollActivated)
          led_d[LED_PO_G] = 1'b0;
        else if (pollEstablished && !configFault)
          led_d[LED_PO_G] = 1'b1;
        else
          led_d[LED_PO_G] = tb.slowPhase;
      end
      default:
        led_d = LED_DARK;
    endcase
  end

  // ============================================================
  // output flops
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      led_q    <= LED_DARK;
      dupAct_q <= 1'b0;
      busDis_q <= 1'b0;
    end
    else
    begin
      led_q    <= led_d;
      dupAct_q <= (state_d == FNSI_DUP);
      busDis_q <= (state_d == FNSI_FAIL);
    end
  end

  assign dupCheckActive = dupAct_q;
  assign busDisable     = busDis_q;
  assign noPeerSeen     = noPeer_q;
  assign faultLatched   = latch_q;
  assign moduleNetGreen = led_q[LED_MN_G];
  assign moduleNetRed   = led_q[LED_MN_R];
  assign pollGreen      = led_q[LED_PO_G];
  assign pollRed        = led_q[LED_PO_R];
  assign strobeGreen    = led_q[LED_BS_G];
  assign strobeRed      = led_q[LED_BS_R];
  assign busFaultRed    = led_q[LED_BF_R];
  assign systemFaultRed = led_q[LED_SF_R];

  // ============================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // sampled reset keeps out the release edge, where flops still hold reset
  sequence lampLit;
    resetn && state_q == FNSI_LAMP && stepIdx_q < STEP_END;
  endsequence
  sequence lampDone;
    state_q == FNSI_LAMP && stepIdx_q == STEP_END;
  endsequence
  sequence runClean;
    state_q == FNSI_RUN && !critical && !minorAny && nodeOnline;
  endsequence

  lamp_one_lit_a: assert property (
    lampLit |=> $onehot(led_q) && led_q == fnsi_lamp_led($past(stepIdx_q)))
    else $error("lamp test pattern wrong");

  lamp_dark_end_a: assert property (
    lampDone |=> led_q == LED_DARK ##0 state_q == FNSI_DUP ##1 dupAct_q)
    else $error("lamp test end wrong");

  dup_fail_red_a: assert property (
    (state_q == FNSI_DUP && dupAddrFound) |=> busDis_q
      ##1 (led_q == 8'h2A && busDis_q)[*3])
    else $error("duplicate address not shown");

  check_mn_dark_a: assert property (
    state_q == FNSI_DUP |=> !led_q[LED_MN_G] && !led_q[LED_MN_R])
    else $error("module indicator lit in check");

  mn_slow_green_a: assert property (
    (runClean and (configFault || !masterConnected))
      |=> led_q[LED_MN_G] == $past(tb.slowPhase) && !led_q[LED_MN_R])
    else $error("module slow green wrong");

  mn_steady_green_a: assert property (
    (runClean and masterConnected && !configFault) |=> led_q[LED_MN_G])
    else $error("module green missing");

  mn_slow_red_a: assert property (
    (state_q == FNSI_RUN && !critical && minorAny)
      |=> led_q[LED_MN_R] == $past(tb.slowPhase) && !led_q[LED_MN_G])
    else $error("module slow red wrong");

  critical_red_a: assert property (
    (state_q == FNSI_RUN && critical)
      |=> led_q[LED_MN_R] && led_q[LED_PO_R] && !led_q[LED_PO_G])
    else $error("critical fault not red");

  poll_fast_a: assert property (
    state_q == FNSI_DUP |=> led_q[LED_PO_G] == $past(tb.fastPhase))
    else $error("polled fast flash wrong");

  poll_dark_a: assert property (
    (state_q == FNSI_RUN && !critical && !minorFault && !pollTimeout
      && !latch_q && !pollActivated) |=> !led_q[LED_PO_G] && !led_q[LED_PO_R])
    else $error("polled indicator not dark");

  fault_latch_a: assert property (
    latchSet |=> latch_q ##1 (latch_q || $past(unitReset)))
    else $error("timeout fault not held");

  lone_hint_a: assert property (
    (state_q == FNSI_DUP && !dupAddrFound && !dupCheckPass && noPeer_q)
      |=> state_q == FNSI_DUP && noPeer_q)
    else $error("check left without a peer");
endmodule
`default_nettype wire

// ==== dv/fnsi_peer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// peer station on the bus: answers the address check
module fnsi_peer_model
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        dupCheckActive, // node is checking
  input  wire logic        twinMode,       // peer owns our address
  input  wire logic [15:0] answerDelay,    // cycles before answer
  output var  logic        dupCheckPass,
  output var  logic        dupAddrFound
);
  logic [15:0] waitCnt_q; // cycles spent in this check

  // ============================================================
  // restart outside the check so each check waits afresh
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      waitCnt_q <= 16'h0000;
    else if (!dupCheckActive)
      waitCnt_q <= 16'h0000;
    else if (waitCnt_q != answerDelay)
      waitCnt_q <= waitCnt_q + 16'h0001;
  end

  // the peer answers answerDelay cycles into the check; both lines low between checks
  assign dupCheckPass = dupCheckActive && (waitCnt_q == answerDelay)
                        && !twinMode;
  assign dupAddrFound = dupCheckActive && (waitCnt_q == answerDelay)
                        && twinMode;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench for the status indicators
module testbench
  import fnsi_pkg::*;
;
  localparam int TC    = 4;                        // cycles per tick
  localparam int STEP  = STEP_TICKS * TC;          // lamp step
  localparam int FASTP = 2 * FAST_HALF_TICKS * TC; // fast period
  localparam int SLOWP = 2 * SLOW_HALF_TICKS * TC; // slow period
  localparam int WAITC = DUP_WAIT_TICKS * TC;      // lone-peer wait
  logic        mclk = 1'b0;
  logic        resetn;
  logic [11:0] stim;         // packed level inputs, see run_case
  logic        twinMode;     // peer claims our address
  logic [15:0] answerDelay;  // peer answer delay in cycles
  logic        dupCheckPass, dupAddrFound;
  logic        dupCheckActive, busDisable, noPeerSeen, faultLatched;
  logic        moduleNetGreen, moduleNetRed, pollGreen, pollRed;
  logic        strobeGreen, strobeRed, busFaultRed, systemFaultRed;
  logic [7:0]  leds;         // same order as the package layout
  logic [15:0] cG, cR, pG, pR, oth; // lit-cycle counters
  logic        latQ = 1'b0;  // expected latched timeout fault
  logic [31:0] rngQ = 32'hF4745271;
  int          numErrors = 0;
  int          checkCount = 0;
  assign leds = {systemFaultRed, busFaultRed, strobeRed, strobeGreen,
                 pollRed, pollGreen, moduleNetRed, moduleNetGreen};

  // ============================================================
  // instances: short tick so the run stays small
  fnsi_indicators #(.TICK_CYCLES(TC)) uut (
    .mclk(mclk), .resetn(resetn), .nodeOnline(stim[11]),
    .masterConnected(stim[10]), .configFault(stim[9]),
    .pollActivated(stim[8]), .pollEstablished(stim[7]),
    .pollTimeout(stim[6]), .strobeTimeout(stim[5]),
    .minorFault(stim[4]), .majorFault(stim[3]), .busOff(stim[2]),
    .dupCheckPass(dupCheckPass), .dupAddrFound(dupAddrFound),
    .timeoutRespFault(stim[1]), .unitReset(stim[0]),
    .dupCheckActive(dupCheckActive), .busDisable(busDisable),
    .noPeerSeen(noPeerSeen), .faultLatched(faultLatched),
    .moduleNetGreen(moduleNetGreen), .moduleNetRed(moduleNetRed),
    .pollGreen(pollGreen), .pollRed(pollRed),
    .strobeGreen(strobeGreen), .strobeRed(strobeRed),
    .busFaultRed(busFaultRed), .systemFaultRed(systemFaultRed));
  fnsi_peer_model peer (
    .mclk(mclk), .resetn(resetn), .dupCheckActive(dupCheckActive),
    .twinMode(twinMode), .answerDelay(answerDelay),
    .dupCheckPass(dupCheckPass), .dupAddrFound(dupAddrFound));

  always #50 mclk = ~mclk; // 10 MHz

  // ============================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // codes: 0 dark, 1 green, 2 red, 3 slow green, 4 slow red
  function automatic logic [5:0] codes(input logic [11:0] s,
                                       input logic lat);
    logic       crit;
    logic [2:0] mn, po;
    crit = s[3] | s[2];
    mn = crit ? 3'h2 : (s[4] | s[6] | s[5] | lat) ? 3'h4 :
         !s[11] ? 3'h0 : (s[10] & !s[9]) ? 3'h1 : 3'h3;
    po = crit ? 3'h2 : (s[4] | s[6] | lat) ? 3'h4 :
         (!s[11] | !s[8]) ? 3'h0 :
         (s[7] & !s[9]) ? 3'h1 : 3'h3;
    return {mn, po};
  endfunction

  // expected {green, red} lit cycles over a window of w cycles
  function automatic logic [31:0] lit(input logic [2:0] c,
                                      input int w);
    logic [15:0] g, r;
    g = (c == 3'h1) ? 16'(w) : (c == 3'h3) ? 16'(w / 2) : 16'h0000;
    r = (c == 3'h2) ? 16'(w) : (c == 3'h4) ? 16'(w / 2) : 16'h0000;
    return {g, r};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask

  // count lit cycles at falling edges, where outputs are settled
  task automatic measure(input int w);
    {cG, cR, pG, pR, oth} = '0;
    repeat (w)
    begin
      @(negedge mclk);
      cG += 16'(moduleNetGreen);
      cR += 16'(moduleNetRed);
      pG += 16'(pollGreen);
      pR += 16'(pollRed);
      oth += 16'(|leds[7:4]);
    end
  endtask

  // bounded wait for dupCheckActive (sel 0) or busDisable to reach lvl
  task automatic wait_sig(input int sel, input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (((sel == 0) ? dupCheckActive : busDisable) !== lvl && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic run_case(input logic [11:0] s);
    logic [5:0] c;
    int         w;
    latQ = (s[1] & (s[6] | s[5])) | (latQ & !s[0]);
    c = codes(s, latQ);
    w = (c[5:3] > 3'h2 || c[2:0] > 3'h2) ? SLOWP : 200;
    @(posedge mclk);
    stim <= s;
    repeat (3) @(posedge mclk);
    measure(w);
    check(32'(faultLatched), 32'(latQ));
    check({cG, cR}, lit(c[5:3], w));
    check({pG, pR}, lit(c[2:0], w));
    check(32'(oth), 32'h0);
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // watchdog sized a little above the whole sequence
  initial
  begin
    repeat (98000) @(posedge mclk);
    numErrors++;
    report_and_stop;
  end

  // ============================================================
  // main sequence
  initial
  begin
    int          n;
    logic [31:0] r;
    resetn = 1'b0;
    stim = 12'h000;
    twinMode = 1'b0;
    answerDelay = 16'h05DC; // prompt peer
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    // lamp test: sample each step in its middle
    repeat (STEP / 2) @(posedge mclk);
    for (int k = 0; k < LAMP_STEPS; k++)
    begin
      @(negedge mclk);
      check(32'(leds), 32'(8'h01 << k));
      if (k < LAMP_STEPS - 1)
        repeat (STEP - 1) @(posedge mclk);
    end
    wait_sig(0, 1'b1, STEP, n);
    check(32'(n > STEP/2 - 10 && n < STEP/2 + 20), 32'h1);
    check(32'({leds[7:3], leds[1:0]}), 32'h0);
    measure(FASTP);
    check({cG, cR}, 32'h0);
    check(32'(pR), 32'h0);
    check(32'(pG), 32'(FASTP / 2));
    wait_sig(0, 1'b0, 1000, n);
    check(32'({busDisable, dupCheckActive}), 32'h0);
    $display("test lamp and address check done");
    // run mapping: corner cases first, then random ones
    run_case(12'hDC2); // timeout with faulting response
    run_case(12'hD80); // cause gone, fault still held
    run_case(12'hD81); // outside reset clears it
    run_case(12'hF80); // bad configuration
    for (int i = 0; i < 2; i++)
    begin
      r = xs(rngQ);
      rngQ = r;
      run_case({r[11] | r[25], r[10:4], r[3] & r[20] & r[21],
                r[2] & r[22] & r[23], r[1], r[0] & r[24]});
    end
    $display("test run mapping done");
    // second reset in mid-run, slow peer that owns our address
    @(posedge mclk);
    resetn <= 1'b0;
    stim <= 12'h000;
    twinMode <= 1'b1;
    answerDelay <= 16'(WAITC + 500);
    latQ = 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    // lamp test restarts; reset has dropped the latch and check flags
    repeat (2) @(negedge mclk);
    check(32'(leds), 32'h01);
    check(32'({busDisable, dupCheckActive}), 32'h0);
    check(32'({noPeerSeen, faultLatched}), 32'h0);
    wait_sig(0, 1'b1, 8 * STEP + 100, n);
    repeat (100) @(negedge mclk);
    check(32'(noPeerSeen), 32'h0);
    repeat (WAITC) @(negedge mclk);
    check(32'(noPeerSeen), 32'h1);
    wait_sig(1, 1'b1, 1000, n);
    repeat (2) @(negedge mclk);
    check(32'({busDisable, dupCheckActive}), 32'h2);
    check(32'(leds), 32'h2A);
    $display("test duplicate address done");
    report_and_stop;
  end
endmodule
`default_nettype wire
